// ===== nvsc_pkg.sv
/*
  Package for the nonvolatile SRAM host controller: timing figures,
  derived cycle counts and the sequencer state type.
  Assumes a 20 MHz reference clock.
*/
`default_nettype none
package nvsc_pkg;
  // ----------------------------------------
  // Clock and timing figures
  // ----------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int CLK_NS = 50;
  localparam int RESTORE_MS = 20;
  localparam int SAVE_MS = 8;
  localparam int CMD_US = 100;
  localparam int RECALL_US = 200;
  localparam int GRACE_NS = 25;
  localparam int HW_PULSE_NS = 15;
  localparam int RESTORE_CYC = RESTORE_MS * 1000 * CLK_MHZ;
  localparam int SAVE_CYC = SAVE_MS * 1000 * CLK_MHZ;
  localparam int CMD_CYC = CMD_US * CLK_MHZ;
  localparam int RECALL_CYC = RECALL_US * CLK_MHZ;
  // Least times round up, at least one cycle
  localparam int GRACE_CYC = (GRACE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HW_PULSE_CYC = (HW_PULSE_NS + CLK_NS - 1) / CLK_NS;
  // Access phases: setup, strobe, recovery
  localparam int ACC_CYC = 2;
  localparam int SEQ_READS = 6;
  localparam int CNT_W = 24;
  // ----------------------------------------
  // Commands
  // ----------------------------------------
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_SOFT = 2'h2;
  localparam logic [1:0] CMD_HWSAVE = 2'h3;
  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_IDLE = 3'b001,
    ST_SETUP = 3'b010,
    ST_STROBE = 3'b011,
    ST_RECOV = 3'b100,
    ST_WAIT = 3'b101,
    ST_HSB = 3'b110
  } nvsc_state_t;
endpackage : nvsc_pkg
`default_nettype wire

// ===== nvsc_timer.sv
/*
  Down-counter with load and done flag, used for every wait.
  Assumes the loader and reader share one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module nvsc_timer #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o
);
  logic [W-1:0] count;
  assign done_o = (count == '0);
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= value_i;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end
endmodule : nvsc_timer
`default_nettype wire

// ===== nvsc_host.sv
/*
  Host controller for a byte-wide nonvolatile SRAM: plain reads and writes,
  six-read software command sequences and hardware save pulses.
  Assumes the memory pins are on board; the save/busy pin is open drain
  with a pull-up. Software sequence addresses come from the user.
*/
// Summary of operation
// - Write strobe high during every read
// - Save/busy line released high during accesses
// - Command reads timed by chip select
// - Six reads back to back, strobe high
// - Sixth read data flagged unreliable
`timescale 1ns/100ps
`default_nettype none
module nvsc_host #(
  parameter int AW = 15,
  parameter int DW = 8,
  parameter int RESTORE_CYC = nvsc_pkg::RESTORE_CYC,
  parameter int SAVE_CYC = nvsc_pkg::SAVE_CYC,
  parameter int RECALL_CYC = nvsc_pkg::RECALL_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // User request
  input wire logic req_valid_i,
  input wire logic [1:0] req_cmd_i,
  input wire logic [AW-1:0] req_addr_i,
  input wire logic [DW-1:0] req_wdata_i,
  input wire logic [6*AW-1:0] seq_addr_i,
  input wire logic seq_recall_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [DW-1:0] rsp_rdata_o,
  output logic rsp_unreliable_o,
  // Memory pins
  output logic [AW-1:0] mem_addr_o,
  output logic mem_ce_n_o,
  output logic mem_we_n_o,
  output logic mem_oe_n_o,
  input wire logic [DW-1:0] mem_dq_i,
  output logic [DW-1:0] mem_dq_o,
  output logic mem_dq_oe_o,
  input wire logic hw_save_busy_n_i,
  output logic hw_save_busy_n_o,
  output logic hw_save_busy_n_oe_o
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic busy_s1, busy_s2;
  logic [DW-1:0] dq_s1, dq_s2;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_s1 <= 1'b1;
      busy_s2 <= 1'b1;
      dq_s1 <= '0;
      dq_s2 <= '0;
    end else begin
      busy_s1 <= hw_save_busy_n_i;
      busy_s2 <= busy_s1;
      dq_s1 <= mem_dq_i;
      dq_s2 <= dq_s1;
    end
  end
  wire dev_busy = !busy_s2;
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  nvsc_pkg::nvsc_state_t state, next_state;
  logic [1:0] cmd;
  logic [2:0] rd_idx;
  logic [1:0] ph;
  logic tmr_load;
  logic [nvsc_pkg::CNT_W-1:0] tmr_val;
  logic tmr_done;
  nvsc_timer #(.W(nvsc_pkg::CNT_W)) u_tmr (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .load_i(tmr_load),
    .value_i(tmr_val),
    .done_o(tmr_done)
  );
  wire is_write = (cmd == nvsc_pkg::CMD_WRITE);
  wire is_soft = (cmd == nvsc_pkg::CMD_SOFT);
  wire last_rd = (rd_idx == 3'(nvsc_pkg::SEQ_READS - 1));
  wire ph_done = (ph == 2'(nvsc_pkg::ACC_CYC - 1));
  // Soft command waits processing plus the operation itself
  wire [nvsc_pkg::CNT_W-1:0] soft_wait = seq_recall_i ?
    nvsc_pkg::CNT_W'(nvsc_pkg::CMD_CYC + RECALL_CYC) :
    nvsc_pkg::CNT_W'(nvsc_pkg::CMD_CYC + SAVE_CYC);
  assign req_ready_o = (state == nvsc_pkg::ST_IDLE) && !dev_busy;
  wire take = req_valid_i && req_ready_o;
  // Boot timer load on first cycle after reset
  logic boot_armed;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_armed <= 1'b0;
    end else begin
      boot_armed <= 1'b1;
    end
  end
  wire boot_load = !boot_armed;
  always_comb begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_val = '0;
    case (state)
      nvsc_pkg::ST_BOOT: begin
        if (boot_load) begin
          tmr_load = 1'b1;
          tmr_val = nvsc_pkg::CNT_W'(RESTORE_CYC);
        end else if (tmr_done && !dev_busy) begin
          next_state = nvsc_pkg::ST_IDLE;
        end
      end
      nvsc_pkg::ST_IDLE: begin
        if (take && req_cmd_i == nvsc_pkg::CMD_HWSAVE) begin
          next_state = nvsc_pkg::ST_HSB;
          tmr_load = 1'b1;
          tmr_val = nvsc_pkg::CNT_W'(nvsc_pkg::HW_PULSE_CYC);
        end else if (take) begin
          next_state = nvsc_pkg::ST_SETUP;
        end
      end
      nvsc_pkg::ST_SETUP: next_state = nvsc_pkg::ST_STROBE;
      nvsc_pkg::ST_STROBE: begin
        if (ph_done) next_state = nvsc_pkg::ST_RECOV;
      end
      nvsc_pkg::ST_RECOV: begin
        if (is_soft && !last_rd) begin
          next_state = nvsc_pkg::ST_SETUP;
        end else if (is_soft) begin
          next_state = nvsc_pkg::ST_WAIT;
          tmr_load = 1'b1;
          tmr_val = soft_wait;
        end else begin
          next_state = nvsc_pkg::ST_IDLE;
        end
      end
      nvsc_pkg::ST_HSB: begin
        if (tmr_done) begin
          next_state = nvsc_pkg::ST_WAIT;
          tmr_load = 1'b1;
          tmr_val = nvsc_pkg::CNT_W'(nvsc_pkg::GRACE_CYC + SAVE_CYC);
        end
      end
      nvsc_pkg::ST_WAIT: begin
        // Busy may drop early when no save was needed
        if (tmr_done && !dev_busy) next_state = nvsc_pkg::ST_IDLE;
      end
      default: next_state = nvsc_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= nvsc_pkg::ST_BOOT;
    end else begin
      state <= next_state;
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd <= nvsc_pkg::CMD_READ;
      rd_idx <= '0;
      ph <= '0;
    end else begin
      if (take) cmd <= req_cmd_i;
      if (take) rd_idx <= '0;
      else if (state == nvsc_pkg::ST_RECOV && is_soft && !last_rd) begin
        rd_idx <= rd_idx + 1'b1;
      end
      if (state == nvsc_pkg::ST_STROBE) ph <= ph + 1'b1;
      else ph <= '0;
    end
  end
  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wdata_q;
  // Address moves only while chip select is high or as it falls, never while selected
  wire [2:0] next_idx = take ? 3'h0 :
    (state == nvsc_pkg::ST_RECOV && is_soft && !last_rd) ? rd_idx + 3'h1 :
    rd_idx;
  wire next_soft = take ? (req_cmd_i == nvsc_pkg::CMD_SOFT) : is_soft;
  wire [AW-1:0] next_addr = next_soft ? seq_addr_i[next_idx*AW +: AW] :
    take ? req_addr_i : addr_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_q <= '0;
      wdata_q <= '0;
      mem_addr_o <= '0;
      mem_ce_n_o <= 1'b1;
      mem_we_n_o <= 1'b1;
      mem_oe_n_o <= 1'b1;
      mem_dq_o <= '0;
      mem_dq_oe_o <= 1'b0;
      hw_save_busy_n_oe_o <= 1'b0;
    end else begin
      if (take) addr_q <= req_addr_i;
      if (take) wdata_q <= req_wdata_i;
      mem_addr_o <= next_addr;
      // Chip select leads the write strobe by one cycle
      mem_ce_n_o <= !(next_state == nvsc_pkg::ST_SETUP ||
                      next_state == nvsc_pkg::ST_STROBE);
      mem_we_n_o <= !(next_state == nvsc_pkg::ST_STROBE && is_write);
      mem_oe_n_o <= !(next_state == nvsc_pkg::ST_STROBE && !is_write);
      mem_dq_o <= wdata_q;
      mem_dq_oe_o <= (next_state == nvsc_pkg::ST_STROBE) && is_write;
      // Released high during accesses; driven low only for a save pulse
      hw_save_busy_n_oe_o <= (next_state == nvsc_pkg::ST_HSB);
    end
  end
  assign hw_save_busy_n_o = 1'b0;
  // ----------------------------------------
  // Response
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
      rsp_unreliable_o <= 1'b0;
    end else begin
      rsp_valid_o <= (state == nvsc_pkg::ST_RECOV) && !is_soft ||
                     (state == nvsc_pkg::ST_RECOV) && last_rd;
      if (state == nvsc_pkg::ST_RECOV) rsp_rdata_o <= dq_s2;
      rsp_unreliable_o <= (state == nvsc_pkg::ST_RECOV) && is_soft &&
                          last_rd;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence acc_s;
    !mem_ce_n_o && mem_we_n_o;
  endsequence
  we_in_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !mem_oe_n_o |-> mem_we_n_o) else $error("write strobe low in read");
  hsb_free_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !mem_ce_n_o |-> !hw_save_busy_n_oe_o) else $error("save line driven");
  ce_first_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $fell(mem_ce_n_o) |-> mem_we_n_o) else $error("write before select");
  no_early_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    state == nvsc_pkg::ST_BOOT |-> mem_ce_n_o) else $error("early access");
  busy_block_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    dev_busy |-> !req_ready_o) else $error("ready while busy");
  six_reads_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (state == nvsc_pkg::ST_RECOV && is_soft && !last_rd) |=> acc_s)
    else $error("sequence gap");
  wait_lock_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    state == nvsc_pkg::ST_WAIT |-> mem_ce_n_o && !req_ready_o)
    else $error("access during lockout");
  dq_dir_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    mem_dq_oe_o |-> !mem_we_n_o && !mem_ce_n_o)
    else $error("data driven outside write");
endmodule : nvsc_host
`default_nettype wire

// ===== nvsc_mem_model.sv
/* Memory model on the far side of the host controller.
   Assumes an open-drain busy line with a pull-up outside. */
`timescale 1ns/100ps
`default_nettype none
module nvsc_mem_model #(
  parameter logic [89:0] SEQ = '0,
  parameter logic [14:0] RCL = '0,
  parameter int BOOT_NS = 2000,
  parameter int SAVE_NS = 1000
) (
  // Memory pins
  input wire logic [14:0] addr_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  // Busy line
  input wire logic busy_n_i,
  output logic pull_o
);
  // ----
  // State
  // ----
  logic [7:0] mem [0:32767];
  logic lock = 1'b1;
  logic wlatch = 1'b0;
  logic wz = 1'b0;
  logic wr_on = 1'b0;
  int step = 0;
  // Inverse when idle, so a late sample never matches
  assign dq_o = (!ce_n_i && we_n_i && !oe_n_i && !lock && !wz) ?
    mem[addr_i] : ~mem[addr_i];
  task automatic hold(input int ns);
    lock = 1'b1;
    pull_o = 1'b1;
    #(ns);
    wlatch = 1'b0;
    pull_o = 1'b0;
    lock = 1'b0;
  endtask : hold
  initial hold(BOOT_NS);
  always @(negedge ce_n_i) begin
    wz = !we_n_i;
    wr_on = !we_n_i;
  end
  always @(negedge we_n_i) wr_on = !ce_n_i;
  // Host ends every access with chip select rising
  always @(posedge ce_n_i) begin
    if (!lock && wr_on) begin
      mem[addr_i] = dq_i;
      wlatch = 1'b1;
      step = 0;
    end else if (!lock) begin
      if (addr_i == SEQ[step*15 +: 15] || (step == 5 && addr_i == RCL))
        step = step + 1;
      else
        step = (addr_i == SEQ[14:0]) ? 1 : 0;
      if (step == 6) begin
        step = 0;
        hold(SAVE_NS);
      end
    end
  end
  always @(negedge busy_n_i) begin
    if (!lock) begin
      #25;
      if (wlatch) hold(SAVE_NS);
    end
  end
endmodule : nvsc_mem_model
`default_nettype wire

// ===== nvsc_host_tb.sv
/* Self-checking bench for the host controller.
   Assumes the memory model above on the pins. */
`timescale 1ns/100ps
`default_nettype none
module nvsc_host_tb;
  localparam logic [89:0] SEQ = {15'h1e0f, 15'h0c3a, 15'h5a5a,
    15'h2d2d, 15'h7070, 15'h0b16};
  localparam logic [14:0] RCL = 15'h6606;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic [1:0] req_cmd_i = 2'h0;
  logic [14:0] req_addr_i = 15'h0000;
  logic [7:0] req_wdata_i = 8'h00;
  logic [89:0] seq_addr_i = SEQ;
  logic seq_recall_i = 1'b0;
  logic req_ready_o, rsp_valid_o, rsp_unreliable_o;
  logic [7:0] rsp_rdata_o, mem_dq_i, mem_dq_o;
  logic [14:0] mem_addr_o;
  logic mem_ce_n_o, mem_we_n_o, mem_oe_n_o, mem_dq_oe_o;
  logic busy_o, busy_oe, pull, hw_save_busy_n;
  int bad_count = 0;
  int comparisons = 0;
  logic [9:0] exp_q [$];
  logic [14:0] a_l [6];
  logic [7:0] d_l [6];
  always #25 ref_clk_i = ~ref_clk_i;
  // Open drain with pull-up
  assign hw_save_busy_n = ~(pull | (busy_oe & ~busy_o));
  nvsc_host #(.RESTORE_CYC(64), .SAVE_CYC(16), .RECALL_CYC(16)) dut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .seq_addr_i(seq_addr_i), .seq_recall_i(seq_recall_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .rsp_unreliable_o(rsp_unreliable_o),
    .mem_addr_o(mem_addr_o), .mem_ce_n_o(mem_ce_n_o),
    .mem_we_n_o(mem_we_n_o), .mem_oe_n_o(mem_oe_n_o),
    .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o), .mem_dq_oe_o(mem_dq_oe_o),
    .hw_save_busy_n_i(hw_save_busy_n), .hw_save_busy_n_o(busy_o),
    .hw_save_busy_n_oe_o(busy_oe));
  nvsc_mem_model #(.SEQ(SEQ), .RCL(RCL)) model (
    .addr_i(mem_addr_o), .ce_n_i(mem_ce_n_o), .we_n_i(mem_we_n_o),
    .oe_n_i(mem_oe_n_o), .dq_i(mem_dq_o), .dq_o(mem_dq_i),
    .busy_n_i(hw_save_busy_n), .pull_o(pull));
  // ----
  // Checking
  // ----
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("mismatches %0d of %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic req(input logic [1:0] c, input logic [14:0] a,
                     input logic [7:0] d, input logic [9:0] e);
    int n;
    n = 0;
    while (req_ready_o !== 1'b1) begin
      @(negedge ref_clk_i);
      n++;
      if (n > 5000) begin
        bad_count++;
        close_out();
      end
    end
    req_cmd_i = c;
    req_addr_i = a;
    req_wdata_i = d;
    req_valid_i = 1'b1;
    if (c != nvsc_pkg::CMD_HWSAVE) exp_q.push_back(e);
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
  endtask : req
  always @(negedge ref_clk_i) begin
    if (rsp_valid_o === 1'b1) begin
      if (exp_q.size() == 0) chk(8'h01, 8'h00);
      else begin
        chk({7'h00, rsp_unreliable_o}, {7'h00, exp_q[0][8]});
        if (exp_q[0][9]) chk(rsp_rdata_o, exp_q[0][7:0]);
        void'(exp_q.pop_front());
      end
    end
  end
  always @(negedge mem_ce_n_o) chk({7'h00, mem_we_n_o}, 8'h01);
  initial begin
    #1000000;
    bad_count++;
    close_out();
  end
  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(67864));
    repeat (5) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    // Busy line is free by now; only the restore wait holds ready low
    repeat (50) @(negedge ref_clk_i);
    chk({7'h00, req_ready_o}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      a_l[i] = 15'($urandom);
      d_l[i] = 8'($urandom);
      req(nvsc_pkg::CMD_WRITE, a_l[i], d_l[i], 10'h000);
    end
    for (int i = 0; i < 6; i++)
      req(nvsc_pkg::CMD_READ, a_l[i], 8'h00, {2'b10, d_l[i]});
    req(nvsc_pkg::CMD_HWSAVE, 15'h0000, 8'h00, 10'h000);
    repeat (8) @(negedge ref_clk_i);
    chk({7'h00, hw_save_busy_n}, 8'h00);
    chk({7'h00, req_ready_o}, 8'h00);
    req(nvsc_pkg::CMD_READ, a_l[0], 8'h00, {2'b10, d_l[0]});
    req(nvsc_pkg::CMD_HWSAVE, 15'h0000, 8'h00, 10'h000);
    repeat (4) @(negedge ref_clk_i);
    chk({7'h00, hw_save_busy_n}, 8'h01);
    req(nvsc_pkg::CMD_SOFT, 15'h0000, 8'h00, 10'h100);
    repeat (24) @(negedge ref_clk_i);
    chk({7'h00, hw_save_busy_n}, 8'h00);
    seq_addr_i = {RCL, SEQ[74:0]};
    seq_recall_i = 1'b1;
    req(nvsc_pkg::CMD_SOFT, 15'h0000, 8'h00, 10'h100);
    req(nvsc_pkg::CMD_READ, a_l[1], 8'h00, {2'b10, d_l[1]});
    repeat (10) @(negedge ref_clk_i);
    chk(8'(exp_q.size()), 8'h00);
    close_out();
  end
endmodule : nvsc_host_tb
`default_nettype wire
